/* src/ssp_consts.svh */
// Register offsets, field positions and reset values of the serial port
// error-status block. Included by the design file and the test bench.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// Byte addresses on the register bus.
`define SSP_OFF_CTRL      8'h00
`define SSP_OFF_DATA      8'h04
`define SSP_OFF_STATUS    8'h08

// Field positions inside the control register.
`define SSP_BIT_WRITE_COLLISION_FLAG      7
`define SSP_BIT_OVF       6
`define SSP_BIT_EN        5
`define SSP_BIT_CKP       4

// Field positions inside the status register.
`define SSP_BIT_FULL      0
`define SSP_BIT_BUSY      1

// Reset values.
`define SSP_RST_CTRL      8'h00
`define SSP_RST_BYTE      8'h00

// Bus responses.
`define SSP_RESP_OKAY     2'h0
`define SSP_RESP_SLVERR   2'h2

`endif

/* src/ssp_pkg.sv */
// Types shared by the serial port error-status block.
// Assumes the constants header is on the include path.
package ssp_pkg;

    // Control register layout, most significant field first.
    typedef struct packed {
        logic       write_collision_flag;
        logic       ovf;
        logic       en;
        logic       ckp;
        logic [3:0] mode;
    } ctrl_t;

    // Byte handed over by the shifter when a reception completes.
    typedef struct packed {
        logic       done;
        logic [7:0] data;
    } rx_in_t;

    // Role that the mode field selects.
    typedef enum logic [1:0] {
        ROLE_SPI_MASTER = 2'b00,
        ROLE_SPI_SLAVE  = 2'b01,
        ROLE_I2C        = 2'b10,
        ROLE_NONE       = 2'b11
    } role_t;

    // Reserved mode codes map to no role, so they never raise overflow.
    function automatic role_t decodeRole(input logic [3:0] mode);
        role_t r;
        r = ROLE_NONE;
        unique case (mode)
            4'h0, 4'h1, 4'h2, 4'h3:       r = ROLE_SPI_MASTER;
            4'h4, 4'h5:                   r = ROLE_SPI_SLAVE;
            4'h6, 4'h7, 4'hB, 4'hE, 4'hF: r = ROLE_I2C;
            default:                      r = ROLE_NONE;
        endcase
        return r;
    endfunction : decodeRole

endpackage : ssp_pkg

/* src/ssp_collision_overflow_flags.sv */
// Error-status logic of a synchronous serial port with AXI4-Lite registers.
// Assumes a shifter outside that reports busy and completed bytes on clk_sys.
// What this block does
// R1 - Buffer write during transfer: drop, set collision
// R2 - Software clears the collision flag itself
// R3 - SPI: byte into full buffer sets overflow
// R4 - On overflow keep old buffer, drop byte
// R5 - SPI overflow only possible as slave
// R6 - SPI master transfer starts on buffer write
// R7 - Software reads buffer after every transfer
// R8 - I2C: byte into full buffer sets overflow
// R9 - Software clears the overflow flag itself
// R10 - Flags reset to zero, held until cleared
//
// Added by the designer: the address map and the AXI4-Lite register port.
`include "ssp_consts.svh"

module ssp_collision_overflow_flags (
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // AXI4-Lite write address and data.
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    // AXI4-Lite write response.
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    output logic [1:0]         s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    input  wire logic [7:0]    s_axi_araddr,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    // Shifter side.
    input  wire logic          xferBusy,
    input  ssp_pkg::rx_in_t    rxIn,
    output logic               txStart,
    output logic [7:0]         txByte,
    output ssp_pkg::ctrl_t     ctrlOut
);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Bus state.
    logic        awHave;
    logic        wHave;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  bResp;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic        bValid;
    logic        rValid;
    logic        next_awHave;
    logic        next_wHave;
    logic [7:0]  next_awAddr;
    logic [31:0] next_wData;
    logic [3:0]  next_wStrb;
    logic [1:0]  next_bResp;
    logic [31:0] next_rData;
    logic [1:0]  next_rResp;
    logic        next_bValid;
    logic        next_rValid;

    // Port state.
    ssp_pkg::ctrl_t ctrl;
    ssp_pkg::ctrl_t next_ctrl;
    logic [7:0]     rxBuf;
    logic [7:0]     next_rxBuf;
    logic           bufFull;
    logic           next_bufFull;
    logic [7:0]     next_txByte;
    logic           next_txStart;

    // Decoded strobes.
    logic           wrFire;
    logic           rdFire;
    logic           ctrlWr;
    logic           dataWr;
    logic           dataRd;
    logic           rxLands;
    ssp_pkg::role_t role;

    assign s_axi_awready = !awHave && !bValid;
    assign s_axi_wready  = !wHave && !bValid;
    assign s_axi_arready = !rValid;
    assign s_axi_bvalid  = bValid;
    assign s_axi_bresp   = bResp;
    assign s_axi_rvalid  = rValid;
    assign s_axi_rdata   = rData;
    assign s_axi_rresp   = rResp;
    assign ctrlOut       = ctrl;
    assign role          = ssp_pkg::decodeRole(ctrl.mode);

    // A write executes once both halves are held, so the order is free.
    assign wrFire = awHave && wHave && !bValid;
    assign rdFire = s_axi_arvalid && s_axi_arready;
    // Only byte lane 0 holds register bits; the upper lanes are ignored.
    assign ctrlWr = wrFire && wStrb[0] && awAddr == `SSP_OFF_CTRL;
    assign dataWr = wrFire && wStrb[0] && awAddr == `SSP_OFF_DATA;
    assign dataRd = rdFire && s_axi_araddr == `SSP_OFF_DATA;
    // A read in the same cycle frees the buffer for the arriving byte.
    assign rxLands = rxIn.done && (!bufFull || dataRd);

    // Bus channel bookkeeping and read data.
    always_comb begin
        next_awHave = awHave;
        next_wHave  = wHave;
        next_awAddr = awAddr;
        next_wData  = wData;
        next_wStrb  = wStrb;
        next_bValid = bValid;
        next_bResp  = bResp;
        next_rValid = rValid;
        next_rData  = rData;
        next_rResp  = rResp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHave = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHave = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (wrFire) begin
            next_awHave = 1'b0;
            next_wHave  = 1'b0;
            next_bValid = 1'b1;
            next_bResp  = `SSP_RESP_OKAY;
            // Unmapped addresses answer SLVERR and change nothing.
            if (awAddr != `SSP_OFF_CTRL && awAddr != `SSP_OFF_DATA &&
                awAddr != `SSP_OFF_STATUS) begin
                next_bResp = `SSP_RESP_SLVERR;
            end
        end else if (bValid && s_axi_bready) begin
            next_bValid = 1'b0;
        end
        if (rdFire) begin
            next_rValid = 1'b1;
            next_rResp  = `SSP_RESP_OKAY;
            next_rData  = 32'h0000_0000;
            unique case (s_axi_araddr)
                `SSP_OFF_CTRL: next_rData[7:0] = ctrl;
                `SSP_OFF_DATA: next_rData[7:0] = rxBuf;
                `SSP_OFF_STATUS: begin
                    next_rData[`SSP_BIT_FULL] = bufFull;
                    next_rData[`SSP_BIT_BUSY] = xferBusy;
                end
                default: next_rResp = `SSP_RESP_SLVERR;
            endcase
        end else if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
        end
    end

    // Bus registers.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHave <= 1'b0;
            wHave  <= 1'b0;
            awAddr <= 8'h00;
            wData  <= 32'h0000_0000;
            wStrb  <= 4'h0;
            bValid <= 1'b0;
            bResp  <= `SSP_RESP_OKAY;
            rValid <= 1'b0;
            rData  <= 32'h0000_0000;
            rResp  <= `SSP_RESP_OKAY;
        end else begin
            awHave <= next_awHave;
            wHave  <= next_wHave;
            awAddr <= next_awAddr;
            wData  <= next_wData;
            wStrb  <= next_wStrb;
            bValid <= next_bValid;
            bResp  <= next_bResp;
            rValid <= next_rValid;
            rData  <= next_rData;
            rResp  <= next_rResp;
        end
    end

    // Control, flags, receive buffer and transmit load.
    always_comb begin
        next_ctrl    = ctrl;
        next_rxBuf   = rxBuf;
        next_bufFull = bufFull;
        next_txByte  = txByte;
        next_txStart = 1'b0;
        // R10 software write
        if (ctrlWr) begin
            next_ctrl = wData[7:0];
        end
        // R6 write starts transfer
        if (dataWr && !xferBusy && ctrl.en) begin
            next_txByte  = wData[7:0];
            next_txStart = 1'b1;
        end
        // The dropped byte never reaches txByte; the shift in flight is safe.
        // R1 collision drops write
        if (dataWr && xferBusy) begin
            next_ctrl.write_collision_flag = 1'b1;
        end
        if (dataRd) begin
            next_bufFull = 1'b0;
        end
        // R4 keep old byte
        if (rxLands) begin
            next_rxBuf   = rxIn.data;
            next_bufFull = 1'b1;
        end
        // R3 R5 R8 overflow by role
        if (rxIn.done && !rxLands &&
            (role == ssp_pkg::ROLE_SPI_SLAVE ||
             role == ssp_pkg::ROLE_I2C)) begin
            next_ctrl.ovf = 1'b1;
        end
    end

    // Port registers; the event terms come last so a set beats a clear.
    // Reset clears both flags along with the rest of control.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl    <= `SSP_RST_CTRL;
            rxBuf   <= `SSP_RST_BYTE;
            bufFull <= 1'b0;
            txByte  <= `SSP_RST_BYTE;
            txStart <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            rxBuf   <= next_rxBuf;
            bufFull <= next_bufFull;
            txByte  <= next_txByte;
            txStart <= next_txStart;
        end
    end

    // Sequences shared by the checks below.
    // A buffer write that lands while the shifter is still busy.
    sequence collideSeq;
        dataWr && xferBusy;
    endsequence

    // A completed byte that finds the buffer full with no read in step.
    sequence overrunSeq;
        rxIn.done && bufFull && !dataRd;
    endsequence

    // A colliding write raises the flag and never reaches the shifter.
    AST_WRITE_COLLISION_FLAG_SET: assert property (collideSeq |=> ctrl.write_collision_flag) // R1
        else $error("Collision did not set the flag.");

    AST_WRITE_COLLISION_FLAG_DROP: assert property (collideSeq |=> !txStart && // R1
                                    $stable(txByte))
        else $error("Colliding write reached the shifter.");

    // Overflow must follow an overrun in each role that may raise it.
    AST_OVF_SPI: assert property ((overrunSeq and // R3
                                   role == ssp_pkg::ROLE_SPI_SLAVE)
                                  |=> ctrl.ovf)
        else $error("Slave overrun did not set overflow.");

    // The held byte survives an overrun, and the buffer stays full.
    AST_OVF_KEEP: assert property (overrunSeq |=> $stable(rxBuf) && // R4
                                   bufFull)
        else $error("Overrun changed the held byte.");

    // A master clocks bytes only on demand, so it never sees overflow.
    AST_OVF_MASTER: assert property (role == ssp_pkg::ROLE_SPI_MASTER && // R5
                                     !ctrl.ovf && !ctrlWr |=> !ctrl.ovf)
        else $error("Master mode raised overflow.");

    // Every start must trace back to an accepted buffer write.
    AST_START: assert property (txStart |-> $past(dataWr) && // R6
                                !$past(xferBusy) && $past(ctrl.en))
        else $error("Transfer started without a buffer write.");

    AST_OVF_I2C: assert property ((overrunSeq and // R8
                                   role == ssp_pkg::ROLE_I2C)
                                  |=> ctrl.ovf)
        else $error("I2C overrun did not set overflow.");

    // Both flags read zero on the first cycle after reset.
    AST_FLAGS_RESET: assert property ($past(sys_rst) |-> // R10
                                      !ctrl.write_collision_flag && !ctrl.ovf)
        else $error("A flag was set after reset.");

    // Once set, a flag clears only through a software write.
    AST_WRITE_COLLISION_FLAG_HOLD: assert property (ctrl.write_collision_flag && !ctrlWr // R10
                                    |=> ctrl.write_collision_flag)
        else $error("Collision flag cleared without a write.");

    AST_OVF_HOLD: assert property (ctrl.ovf && !ctrlWr // R10
                                   |=> ctrl.ovf)
        else $error("Overflow flag cleared without a write.");

endmodule : ssp_collision_overflow_flags

/* verification/serial_peer.sv */
// Behavioural serial peer on the shifter side of the flags block.
// Assumes clk_sys and the synchronous active-high reset of the block.
module serial_peer (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Block side.
    input  wire logic        txStart,
    input  wire logic [7:0]  txByte,
    output logic             xferBusy,
    output ssp_pkg::rx_in_t  rxIn,
    // Bench side: a byte sent by a remote master.
    input  wire logic        pushValid,
    input  wire logic [7:0]  pushByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busyLeft;
    logic [7:0] echo;

    // Busy lasts a fixed span after each start, then the inverse byte
    // comes back; the data lines toggle outside a completion pulse.
    // start on load
    always_ff @(posedge clk_sys) begin
        rxIn.done <= 1'b0;
        rxIn.data <= ~rxIn.data;
        if (sys_rst) begin
            busyLeft <= 4'h0;
            rxIn <= '0;
        end else if (txStart) begin
            busyLeft <= 4'h8;
            echo <= ~txByte;
        end else if (busyLeft == 4'h1) begin
            busyLeft <= 4'h0;
            rxIn <= {1'b1, echo};
        end else if (busyLeft != 4'h0) begin
            busyLeft <= busyLeft - 4'h1;
        end else if (pushValid) begin
            rxIn <= {1'b1, pushByte};
        end
    end
    assign xferBusy = (busyLeft != 4'h0);
endmodule : serial_peer

/* verification/ssp_collision_overflow_flags_test.sv */
// Self-checking bench for the serial port error flags.
// Assumes the package, the constants header and the serial peer model.
`include "ssp_consts.svh"
module ssp_collision_overflow_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk_sys, sys_rst, xferBusy, txStart, pushValid;
    logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic            s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic            s_axi_rready;
    logic [7:0]      s_axi_awaddr, s_axi_araddr, txByte, pushByte;
    logic [31:0]     s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]      s_axi_wstrb;
    logic [1:0]      s_axi_bresp, s_axi_rresp, rsp;
    ssp_pkg::rx_in_t rxIn;
    ssp_pkg::ctrl_t  ctrlOut;
    int              miscompares, checkCount, starts;

    ssp_collision_overflow_flags uut (.*);
    serial_peer peer (.*);

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Start pulses are counted mid-cycle, where they are settled.
    always @(negedge clk_sys) begin
        if (txStart === 1'b1) starts++;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Handshakes are judged at the falling edge, acted on at the next rise.
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a);
        logic ar, r;
        r = 1'b0;
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!r) begin
            @(negedge clk_sys);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
    endtask : axiRead

    task automatic push(input logic [7:0] b);
        @(posedge clk_sys);
        pushValid <= 1'b1;
        pushByte <= b;
        @(posedge clk_sys);
        pushValid <= 1'b0;
    endtask : push

    task automatic waitIdle;
        do axiRead(`SSP_OFF_STATUS); while (rd[`SSP_BIT_BUSY] !== 1'b0);
    endtask : waitIdle

    task automatic resetAndMap;
        axiRead(`SSP_OFF_CTRL);
        check("ctrl at reset", rd, 32'h0000_0000);
        axiRead(8'h0C);
        check("unmapped resp", 32'(rsp), 32'(`SSP_RESP_SLVERR));
        check("unmapped data", rd, 32'h0000_0000);
    endtask : resetAndMap

    // A second load while busy must be dropped and flagged.
    task automatic collision;
        axiWrite(`SSP_OFF_CTRL, 32'h0000_0020);
        axiWrite(`SSP_OFF_DATA, 32'h0000_005A);
        axiWrite(`SSP_OFF_DATA, 32'h0000_00C3);
        check("collide resp", 32'(rsp), 32'(`SSP_RESP_OKAY));
        check("starts", starts, 1);
        check("txByte", txByte, 32'h0000_005A);
        waitIdle();
        axiRead(`SSP_OFF_CTRL);
        check("write_collision_flag held", rd, 32'h0000_00A0);
        axiWrite(8'h0C, 32'h0000_0000);
        check("stray resp", 32'(rsp), 32'(`SSP_RESP_SLVERR));
        axiRead(`SSP_OFF_CTRL);
        check("write_collision_flag after stray", rd, 32'h0000_00A0);
        axiRead(`SSP_OFF_DATA);
        check("reply", rd, 32'h0000_00A5);
        axiWrite(`SSP_OFF_CTRL, 32'h0000_0020);
        check("write_collision_flag clear", ctrlOut, 32'h0000_0020);
    endtask : collision

    // Master modes never flag overflow, slave and two-wire modes do.
    task automatic overflow(input logic [3:0] m, input logic slave);
        axiWrite(`SSP_OFF_CTRL, {24'h0, 4'h2, m});
        push(8'h3C);
        push(8'h96);
        axiRead(`SSP_OFF_CTRL);
        check("ovf", rd[`SSP_BIT_OVF], slave);
        axiRead(`SSP_OFF_STATUS);
        check("full", rd, 32'h0000_0001);
        axiRead(`SSP_OFF_DATA);
        check("old byte kept", rd, 32'h0000_003C);
        // A byte that lands cleanly must not clear a set flag.
        push(8'h71);
        axiRead(`SSP_OFF_CTRL);
        check("ovf held", rd[`SSP_BIT_OVF], slave);
        axiRead(`SSP_OFF_DATA);
        check("byte after drain", rd, 32'h0000_0071);
        axiWrite(`SSP_OFF_CTRL, {24'h0, 4'h2, m});
        push(8'h55);
        axiRead(`SSP_OFF_DATA);
        push(8'h66);
        axiRead(`SSP_OFF_CTRL);
        check("ovf after reads", rd[`SSP_BIT_OVF], 1'b0);
        axiRead(`SSP_OFF_DATA);
        check("fresh byte", rd, 32'h0000_0066);
    endtask : overflow

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : endOfTest

    // Watchdog, far beyond the few hundred cycles the run needs.
    initial begin
        #200us;
        miscompares++;
        endOfTest();
    end

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        // Each entry: overflow expected in bit 4, then the mode code.
        logic [4:0] modes[13];
        modes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h14, 5'h15, 5'h16,
                  5'h17, 5'h1B, 5'h1E, 5'h1F, 5'h08, 5'h0C};
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, pushValid} = '0;
        {s_axi_awaddr, s_axi_araddr, pushByte} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        resetAndMap();
        collision();
        foreach (modes[i]) overflow(modes[i][3:0], modes[i][4]);
        endOfTest();
    end
endmodule : ssp_collision_overflow_flags_test
